// ==== lgp_pkg.sv ====
// Purpose: Shared constants and types for the LCD-shared GPIO ports
// Assumes: APB with 32-bit data; register byte address is four times the index
// Notes: Pin states follow the power mode supplied by the system controller
package lgp_pkg;
	// Bus geometry
	localparam int LGP_ADDR_W = 18;
	localparam int LGP_DATA_W = 32;

	// Register indices and byte addresses
	localparam logic [15:0] LGP_WIDE_LATCH_IDX = 16'hffdc;
	localparam logic [15:0] LGP_WIDE_DIR_IDX = 16'hffec;
	localparam logic [15:0] LGP_NARROW_LATCH_IDX = 16'hffdd;
	localparam logic [15:0] LGP_NARROW_DIR_IDX = 16'hffed;
	localparam logic [15:0] LGP_CTRL_IDX = 16'hffd0;
	localparam logic [LGP_ADDR_W-1:0] LGP_WIDE_LATCH_ADDR = {LGP_WIDE_LATCH_IDX, 2'b00};
	localparam logic [LGP_ADDR_W-1:0] LGP_WIDE_DIR_ADDR = {LGP_WIDE_DIR_IDX, 2'b00};
	localparam logic [LGP_ADDR_W-1:0] LGP_NARROW_LATCH_ADDR = {LGP_NARROW_LATCH_IDX, 2'b00};
	localparam logic [LGP_ADDR_W-1:0] LGP_NARROW_DIR_ADDR = {LGP_NARROW_DIR_IDX, 2'b00};
	localparam logic [LGP_ADDR_W-1:0] LGP_CTRL_ADDR = {LGP_CTRL_IDX, 2'b00};

	// Reset and read-back values
	localparam logic [7:0] LGP_WIDE_LATCH_RST = 8'h00;
	localparam logic [7:0] LGP_WIDE_DIR_RST = 8'h00;
	localparam logic [7:0] LGP_NARROW_LATCH_RST = 8'hf0;
	localparam logic [7:0] LGP_NARROW_DIR_RST = 8'hf0;
	localparam logic [7:0] LGP_DIR_READ = 8'hff;
	localparam logic [11:0] LGP_CTRL_RST = 12'h000;

	// Control register fields
	localparam int LGP_SEG_LSB = 0;
	localparam int LGP_SEG_W = 4;
	localparam int LGP_EXP_BIT = 4;
	localparam int LGP_NLCD_LSB = 8;
	localparam int LGP_NLCD_W = 4;
	localparam logic [3:0] LGP_SEG_GPIO = 4'h0;

	// Power modes from the system controller
	typedef enum logic [2:0] {
		LGP_MODE_ACTIVE = 3'b000,
		LGP_MODE_SUBACTIVE = 3'b001,
		LGP_MODE_SLEEP = 3'b010,
		LGP_MODE_SUBSLEEP = 3'b011,
		LGP_MODE_STANDBY = 3'b100,
		LGP_MODE_WATCH = 3'b101
	} lgp_mode_t;

	// Decoded register selection
	typedef enum logic [2:0] {
		LGP_REG_NONE = 3'b000,
		LGP_REG_WIDE_LATCH = 3'b001,
		LGP_REG_WIDE_DIR = 3'b010,
		LGP_REG_NARROW_LATCH = 3'b011,
		LGP_REG_NARROW_DIR = 3'b100,
		LGP_REG_CTRL = 3'b101
	} lgp_reg_t;

	// Signals from the LCD controller
	typedef struct packed {
		logic [7:0] segment_output;
		logic clk_one;
		logic clk_two;
		logic ser_data;
		logic alt;
		logic [3:0] narrow;
	} lgp_lcd_t;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [LGP_ADDR_W-1:0] paddr;
		logic [LGP_DATA_W-1:0] pwdata;
		logic [3:0] pstrb;
	} lgp_apb_req_t;
endpackage

// ==== lgp_ports.sv ====
// What this block does
// - Upper wide pins, expansion off, segment field zero: direction bit picks input/output.
// - Upper wide pins, expansion off, field nonzero: drive segments 40 to 37.
// - Expansion on: bits 7..4 drive clock one, clock two, serial data, alternation.
// - Lower wide pins: field zero gives GPIO, otherwise pin n drives segment n+33.
// - Wide pins float in reset/standby, hold in sleep/subsleep/watch, run otherwise.
// - Narrow latch holds low nibble, upper bits read one, resets to f0.
// - Narrow port read returns latch where direction bit is one.
// - Narrow port read returns live pin where direction bit is zero.
// - Narrow direction bit one makes an output, zero an input.
// - Narrow settings act only while the pin is assigned to general I/O.
// - Narrow direction register is write-only, reads all ones, resets to f0.
// - Wide port read gives latch for outputs, pin for inputs; latch resets zero.
// - Wide direction register write-only, reads all ones, resets to zero.
//
// Purpose: Eight-bit LCD-shared port and four-bit port with APB registers
// Assumes: Power mode and LCD signals come from logic on ref_clk
// Notes: Pin outputs are registered, so pins follow settings one cycle late
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module lgp_ports (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// APB slave
	input wire lgp_pkg::lgp_apb_req_t apb_req,
	output logic pready,
	output logic [lgp_pkg::LGP_DATA_W-1:0] prdata,
	output logic pslverr,
	// System state and LCD controller
	input wire lgp_pkg::lgp_mode_t power_mode,
	input wire lgp_pkg::lgp_lcd_t lcd,
	// Wide port pins
	input wire logic [7:0] wide_pin_in,
	output logic [7:0] wide_pin_out,
	output logic [7:0] wide_pin_oe,
	// Narrow port pins
	input wire logic [3:0] narrow_pin_in,
	output logic [3:0] narrow_pin_out,
	output logic [3:0] narrow_pin_oe
);
	import lgp_pkg::*;

	function automatic lgp_reg_t reg_decode(input logic [LGP_ADDR_W-1:0] addr);
		case (addr)
			LGP_WIDE_LATCH_ADDR: reg_decode = LGP_REG_WIDE_LATCH;
			LGP_WIDE_DIR_ADDR: reg_decode = LGP_REG_WIDE_DIR;
			LGP_NARROW_LATCH_ADDR: reg_decode = LGP_REG_NARROW_LATCH;
			LGP_NARROW_DIR_ADDR: reg_decode = LGP_REG_NARROW_DIR;
			LGP_CTRL_ADDR: reg_decode = LGP_REG_CTRL;
			default: reg_decode = LGP_REG_NONE;
		endcase
	endfunction

	// Pin synchronisers
	logic [7:0] wide_s1_r, wide_s1_nxt, wide_s2_r, wide_s2_nxt;
	logic [3:0] narrow_s1_r, narrow_s1_nxt, narrow_s2_r, narrow_s2_nxt;

	always_comb begin
		wide_s1_nxt = wide_pin_in;
		wide_s2_nxt = wide_s1_r;
		narrow_s1_nxt = narrow_pin_in;
		narrow_s2_nxt = narrow_s1_r;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wide_s1_r <= 8'h00;
			wide_s2_r <= 8'h00;
			narrow_s1_r <= 4'h0;
			narrow_s2_r <= 4'h0;
		end else if (clk_en) begin
			wide_s1_r <= wide_s1_nxt;
			wide_s2_r <= wide_s2_nxt;
			narrow_s1_r <= narrow_s1_nxt;
			narrow_s2_r <= narrow_s2_nxt;
		end
	end

	// Register file
	logic [7:0] wide_latch_r, wide_latch_nxt, wide_dir_r, wide_dir_nxt;
	logic [3:0] narrow_latch_r, narrow_latch_nxt, narrow_dir_r, narrow_dir_nxt;
	logic [11:0] ctrl_r, ctrl_nxt;
	logic [LGP_DATA_W-1:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [3:0] seg_sel;
	logic exp_sel;
	logic [3:0] narrow_lcd;
	logic [7:0] wide_rd;
	logic [3:0] narrow_rd;
	lgp_reg_t sel;
	logic wr_en, setup, access, capture;
	// Set once read data is captured for the transfer in flight
	logic armed_r, armed_nxt;

	assign seg_sel = ctrl_r[LGP_SEG_LSB +: LGP_SEG_W];
	assign exp_sel = ctrl_r[LGP_EXP_BIT];
	assign narrow_lcd = ctrl_r[LGP_NLCD_LSB +: LGP_NLCD_W];
	// Zero wait states normally; a setup edge lost to a low enable costs one
	assign pready = clk_en && armed_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign sel = reg_decode(apb_req.paddr);
	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	// Without this a frozen setup edge would hand back stale read data
	assign capture = setup || (access && !armed_r);
	assign wr_en = access && armed_r && apb_req.pwrite && apb_req.pstrb[0];
	// Outputs read back their latch, inputs the synchronised pin
	assign wide_rd = (wide_dir_r & wide_latch_r) | (~wide_dir_r & wide_s2_r);
	assign narrow_rd = (narrow_dir_r & narrow_latch_r) | (~narrow_dir_r & narrow_s2_r);

	always_comb begin
		wide_latch_nxt = wide_latch_r;
		wide_dir_nxt = wide_dir_r;
		narrow_latch_nxt = narrow_latch_r;
		narrow_dir_nxt = narrow_dir_r;
		ctrl_nxt = ctrl_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		armed_nxt = armed_r;
		if (wr_en) begin
			case (sel)
				LGP_REG_WIDE_LATCH: wide_latch_nxt = apb_req.pwdata[7:0];
				LGP_REG_WIDE_DIR: wide_dir_nxt = apb_req.pwdata[7:0];
				LGP_REG_NARROW_LATCH: narrow_latch_nxt = apb_req.pwdata[3:0];
				LGP_REG_NARROW_DIR: narrow_dir_nxt = apb_req.pwdata[3:0];
				LGP_REG_CTRL: ctrl_nxt = apb_req.pwdata[11:0];
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		// Read data is captured in the setup cycle and held for the access phase
		if (capture) begin
			armed_nxt = 1'b1;
			prdata_nxt = '0;
			pslverr_nxt = 1'b0;
			case (sel)
				LGP_REG_WIDE_LATCH: prdata_nxt[7:0] = wide_rd;
				LGP_REG_WIDE_DIR: prdata_nxt[7:0] = LGP_DIR_READ;
				LGP_REG_NARROW_LATCH: begin
					prdata_nxt[7:0] = {LGP_NARROW_LATCH_RST[7:4], narrow_rd};
				end
				LGP_REG_NARROW_DIR: prdata_nxt[7:0] = LGP_DIR_READ;
				LGP_REG_CTRL: prdata_nxt[11:0] = ctrl_r;
				default: pslverr_nxt = 1'b1;
			endcase
		end else if (access) begin
			armed_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wide_latch_r <= LGP_WIDE_LATCH_RST;
			wide_dir_r <= LGP_WIDE_DIR_RST;
			narrow_latch_r <= LGP_NARROW_LATCH_RST[3:0];
			narrow_dir_r <= LGP_NARROW_DIR_RST[3:0];
			ctrl_r <= LGP_CTRL_RST;
			prdata_r <= '0;
			pslverr_r <= 1'b0;
			armed_r <= 1'b0;
		end else if (clk_en) begin
			wide_latch_r <= wide_latch_nxt;
			wide_dir_r <= wide_dir_nxt;
			narrow_latch_r <= narrow_latch_nxt;
			narrow_dir_r <= narrow_dir_nxt;
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			armed_r <= armed_nxt;
		end
	end

	// Pin role selection
	logic [7:0] wide_fn_out, wide_fn_oe;
	logic [3:0] narrow_fn_out, narrow_fn_oe;
	logic [3:0] exp_vec;

	assign exp_vec = {lcd.clk_one, lcd.clk_two, lcd.ser_data, lcd.alt};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_wide
			always_comb begin
				if (gi >= 4 && exp_sel) begin
					wide_fn_oe[gi] = 1'b1;
					wide_fn_out[gi] = exp_vec[gi % 4];
				end else if (seg_sel != LGP_SEG_GPIO) begin
					// Segment gi drives segment number 33 + gi
					wide_fn_oe[gi] = 1'b1;
					wide_fn_out[gi] = lcd.segment_output[gi];
				end else begin
					wide_fn_oe[gi] = wide_dir_r[gi];
					wide_fn_out[gi] = wide_latch_r[gi];
				end
			end
		end
		for (gi = 0; gi < 4; gi++) begin : g_narrow
			always_comb begin
				if (narrow_lcd[gi]) begin
					narrow_fn_oe[gi] = 1'b1;
					narrow_fn_out[gi] = lcd.narrow[gi];
				end else begin
					narrow_fn_oe[gi] = narrow_dir_r[gi];
					narrow_fn_out[gi] = narrow_latch_r[gi];
				end
			end
		end
	endgenerate

	// Registered pin drivers; reset clears the enables so pins float
	logic [7:0] wide_out_r, wide_out_nxt, wide_oe_r, wide_oe_nxt;
	logic [3:0] narrow_out_r, narrow_out_nxt, narrow_oe_r, narrow_oe_nxt;

	always_comb begin
		wide_out_nxt = wide_out_r;
		wide_oe_nxt = wide_oe_r;
		narrow_out_nxt = narrow_out_r;
		narrow_oe_nxt = narrow_oe_r;
		case (power_mode)
			LGP_MODE_ACTIVE, LGP_MODE_SUBACTIVE: begin
				wide_out_nxt = wide_fn_out;
				wide_oe_nxt = wide_fn_oe;
				narrow_out_nxt = narrow_fn_out;
				narrow_oe_nxt = narrow_fn_oe;
			end
			LGP_MODE_STANDBY: begin
				wide_out_nxt = 8'h00;
				wide_oe_nxt = 8'h00;
				narrow_out_nxt = 4'h0;
				narrow_oe_nxt = 4'h0;
			end
			// Sleep, subsleep and watch keep the last drive
			default: wide_oe_nxt = wide_oe_r;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wide_out_r <= 8'h00;
			wide_oe_r <= 8'h00;
			narrow_out_r <= 4'h0;
			narrow_oe_r <= 4'h0;
		end else if (clk_en) begin
			wide_out_r <= wide_out_nxt;
			wide_oe_r <= wide_oe_nxt;
			narrow_out_r <= narrow_out_nxt;
			narrow_oe_r <= narrow_oe_nxt;
		end
	end

	assign wide_pin_out = wide_out_r;
	assign wide_pin_oe = wide_oe_r;
	assign narrow_pin_out = narrow_out_r;
	assign narrow_pin_oe = narrow_oe_r;

	// Checks
	logic run_mode;
	assign run_mode = (power_mode == LGP_MODE_ACTIVE) || (power_mode == LGP_MODE_SUBACTIVE);

	a_upper_gpio_dir: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && run_mode && !exp_sel && seg_sel == LGP_SEG_GPIO)
		|=> (wide_pin_oe[7:4] == $past(wide_dir_r[7:4]))
		&& (wide_pin_out[7:4] == $past(wide_latch_r[7:4])))
		else $error("upper pins do not follow direction and latch");

	a_upper_seg_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && run_mode && !exp_sel && seg_sel != LGP_SEG_GPIO)
		|=> (wide_pin_oe[7:4] == 4'hf) && (wide_pin_out[7:4] == $past(lcd.segment_output[7:4])))
		else $error("upper pins do not drive segments");

	a_expansion_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && run_mode && exp_sel)
		|=> (wide_pin_oe[7:4] == 4'hf) && (wide_pin_out[7] == $past(lcd.clk_one))
		&& (wide_pin_out[6] == $past(lcd.clk_two)) && (wide_pin_out[5] == $past(lcd.ser_data))
		&& (wide_pin_out[4] == $past(lcd.alt)))
		else $error("expansion signals not on upper pins");

	a_lower_seg_role: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && run_mode)
		|=> (wide_pin_oe[3:0] == (($past(seg_sel) != LGP_SEG_GPIO) ? 4'hf : $past(wide_dir_r[3:0])))
		&& (wide_pin_out[3:0] == (($past(seg_sel) != LGP_SEG_GPIO) ?
			$past(lcd.segment_output[3:0]) : $past(wide_latch_r[3:0]))))
		else $error("lower pins in wrong role");

	a_standby_float: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && power_mode == LGP_MODE_STANDBY)
		|=> (wide_pin_oe == 8'h00) && (narrow_pin_oe == 4'h0))
		else $error("pins driven in standby");

	a_sleep_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && (power_mode == LGP_MODE_SLEEP || power_mode == LGP_MODE_SUBSLEEP
		|| power_mode == LGP_MODE_WATCH))
		|=> $stable(wide_pin_oe) && $stable(wide_pin_out) && $stable(narrow_pin_oe))
		else $error("pins changed while held");

	a_narrow_read: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && setup && sel == LGP_REG_NARROW_LATCH)
		|=> (prdata[7:4] == 4'hf) && (prdata[3:0] == (($past(narrow_dir_r) & $past(narrow_latch_r))
		| (~$past(narrow_dir_r) & $past(narrow_s2_r)))))
		else $error("narrow port read value wrong");

	a_wide_read: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && setup && sel == LGP_REG_WIDE_LATCH)
		|=> (prdata[7:0] == (($past(wide_dir_r) & $past(wide_latch_r))
		| (~$past(wide_dir_r) & $past(wide_s2_r)))) && !pslverr)
		else $error("wide port read value wrong");

	a_dir_reads_ones: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && setup && (sel == LGP_REG_NARROW_DIR || sel == LGP_REG_WIDE_DIR))
		|=> (prdata == 32'h0000_00ff))
		else $error("direction register did not read all ones");

	a_narrow_dir_out: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && run_mode && narrow_lcd == 4'h0)
		|=> (narrow_pin_oe == $past(narrow_dir_r)) && (narrow_pin_out == $past(narrow_latch_r)))
		else $error("narrow pins ignore direction or latch");

	a_narrow_lcd_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && run_mode)
		|=> ((narrow_pin_oe & $past(narrow_lcd)) == $past(narrow_lcd))
		&& (((narrow_pin_out ^ $past(lcd.narrow)) & $past(narrow_lcd)) == 4'h0))
		else $error("narrow pins do not carry LCD values");

	a_narrow_dir_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && wr_en && sel == LGP_REG_NARROW_DIR)
		|=> (narrow_dir_r == $past(apb_req.pwdata[3:0])))
		else $error("narrow direction write lost");

	a_narrow_latch_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && wr_en && sel == LGP_REG_NARROW_LATCH)
		|=> (narrow_latch_r == $past(apb_req.pwdata[3:0])))
		else $error("narrow latch write lost");

	a_wide_latch_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && wr_en && sel == LGP_REG_WIDE_LATCH)
		|=> (wide_latch_r == $past(apb_req.pwdata[7:0])))
		else $error("wide latch write lost");

	a_wide_dir_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clk_en && wr_en && sel == LGP_REG_WIDE_DIR)
		|=> (wide_dir_r == $past(apb_req.pwdata[7:0])))
		else $error("wide direction write lost");
endmodule

// ==== lgp_pin_model.sv ====
// Purpose: Board-side model of the pins of both ports
// Assumes: Outside world drives a level only where the port does not
// Notes: A driven pin reads back what the port drives, else the outside level
`timescale 1ns/1ps
module lgp_pin_model #(
	parameter int W = 8
) (
	// Port side
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	// Outside level
	input wire logic [W-1:0] ext_level,
	// Level seen by the port
	output logic [W-1:0] pin_in
);
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule

// ==== lcd_shared_gpio_ports_tb.sv ====
// Purpose: Self-checking bench for the LCD-shared GPIO ports
// Assumes: Zero-wait APB slave, pins registered one edge after their cause
// Notes: Pin reads wait three edges for the two-flop synchroniser
`timescale 1ns/1ps
module lcd_shared_gpio_ports_tb;
	import lgp_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	lgp_apb_req_t req = '0;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic err;
	lgp_mode_t power_mode = LGP_MODE_ACTIVE;
	lgp_lcd_t lcd = '0;
	logic [7:0] wide_in, wide_out, wide_oe;
	logic [7:0] wide_ext = 8'h00;
	logic [3:0] narrow_in, narrow_out, narrow_oe;
	logic [3:0] narrow_ext = 4'h0;
	int failures = 0;
	int tests_run = 0;

	lgp_ports u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .apb_req(req),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .power_mode(power_mode),
		.lcd(lcd), .wide_pin_in(wide_in), .wide_pin_out(wide_out), .wide_pin_oe(wide_oe),
		.narrow_pin_in(narrow_in), .narrow_pin_out(narrow_out), .narrow_pin_oe(narrow_oe));
	lgp_pin_model #(.W(8)) u_wide_pins (.pin_out(wide_out), .pin_oe(wide_oe),
		.ext_level(wide_ext), .pin_in(wide_in));
	lgp_pin_model #(.W(4)) u_narrow_pins (.pin_out(narrow_out), .pin_oe(narrow_oe),
		.ext_level(narrow_ext), .pin_in(narrow_in));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		req.pstrb <= 4'hf;
		@(posedge ref_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic t_reset;
		settle(11);
		chk({wide_oe, narrow_oe}, 32'h0);
		@(posedge ref_clk);
		resetn <= 1'b1;
		settle(3);
		apb(1'b0, LGP_WIDE_DIR_ADDR, 0);
		chk(rd, 32'hff);
		apb(1'b0, LGP_NARROW_DIR_ADDR, 0);
		chk(rd, 32'hff);
		apb(1'b0, LGP_NARROW_LATCH_ADDR, 0);
		chk(rd, 32'hf0);
		apb(1'b0, 18'h00000, 0);
		chk({err, rd}, {1'b1, 32'h0});
	endtask

	task automatic t_wide_gpio;
		@(posedge ref_clk);
		wide_ext <= 8'h3c;
		apb(1'b1, LGP_WIDE_DIR_ADDR, 32'hff);
		apb(1'b1, LGP_WIDE_LATCH_ADDR, 32'ha5);
		settle(2);
		chk({wide_out, wide_oe}, 16'ha5ff);
		apb(1'b0, LGP_WIDE_LATCH_ADDR, 0);
		chk(rd, 32'ha5);
		apb(1'b1, LGP_WIDE_DIR_ADDR, 32'h0f);
		settle(3);
		chk(wide_oe, 8'h0f);
		apb(1'b0, LGP_WIDE_LATCH_ADDR, 0);
		chk(rd, 32'h35);
	endtask

	// Direction still 0f: segments must override it
	task automatic t_segment;
		logic [3:0] fld[2] = '{4'h1, 4'h8};
		foreach (fld[i]) begin
			@(posedge ref_clk);
			lcd.segment_output <= 8'h96 ^ {4'h0, fld[i]};
			apb(1'b1, LGP_CTRL_ADDR, {28'h0, fld[i]});
			settle(2);
			chk({wide_out, wide_oe}, {8'h96 ^ {4'h0, fld[i]}, 8'hff});
		end
	endtask

	task automatic t_expansion;
		@(posedge ref_clk);
		lcd <= '{segment_output: 8'h0f, clk_one: 1'b1, clk_two: 1'b0, ser_data: 1'b1, alt: 1'b0,
			narrow: 4'h0};
		apb(1'b1, LGP_CTRL_ADDR, 32'h11);
		settle(2);
		chk({wide_out, wide_oe}, 16'hafff);
	endtask

	task automatic t_modes;
		lgp_mode_t hold[3] = '{LGP_MODE_SLEEP, LGP_MODE_SUBSLEEP, LGP_MODE_WATCH};
		@(posedge ref_clk);
		power_mode <= LGP_MODE_STANDBY;
		settle(2);
		chk({wide_out, wide_oe}, 16'h0000);
		foreach (hold[i]) begin
			@(posedge ref_clk);
			power_mode <= LGP_MODE_ACTIVE;
			lcd.segment_output <= 8'h0f;
			settle(2);
			@(posedge ref_clk);
			power_mode <= hold[i];
			settle(1);
			@(posedge ref_clk);
			lcd.segment_output <= 8'h00;
			settle(3);
			chk({wide_out, wide_oe}, 16'hafff);
		end
		@(posedge ref_clk);
		power_mode <= LGP_MODE_SUBACTIVE;
		settle(2);
		chk({wide_out, wide_oe}, 16'ha0ff);
	endtask

	task automatic t_narrow;
		@(posedge ref_clk);
		narrow_ext <= 4'h5;
		apb(1'b1, LGP_NARROW_DIR_ADDR, 32'h3);
		apb(1'b1, LGP_NARROW_LATCH_ADDR, 32'ha);
		settle(3);
		chk({narrow_out & narrow_oe, narrow_oe}, 8'h23);
		apb(1'b0, LGP_NARROW_LATCH_ADDR, 0);
		chk(rd, 32'hf6);
		apb(1'b0, LGP_NARROW_DIR_ADDR, 0);
		chk(rd, 32'hff);
		@(posedge ref_clk);
		lcd.narrow <= 4'h4;
		apb(1'b1, LGP_CTRL_ADDR, 32'h400);
		settle(2);
		chk({narrow_out[2], narrow_oe[2], narrow_oe[1:0]}, 4'hf);
	endtask

	// Low enable freezes pins; a read with a frozen setup edge still gets fresh data
	task automatic t_freeze;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		lcd.narrow <= 4'h0;
		settle(3);
		chk(narrow_out[2], 1'b1);
		fork
			apb(1'b0, LGP_NARROW_LATCH_ADDR, 0);
			begin
				repeat (4) @(posedge ref_clk);
				clk_en <= 1'b1;
			end
		join
		chk(rd, 32'hf6);
		settle(2);
		chk(narrow_out[2], 1'b0);
	endtask

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		t_reset();
		t_wide_gpio();
		t_segment();
		t_expansion();
		t_modes();
		t_narrow();
		t_freeze();
		give_verdict();
	end

	// Whole run is under 150 cycles; the 20000-cycle limit is ample margin
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule
